// ==== rtl/gated_pulse_counter.v ====
// Purpose: finite pulse train generator pair and pulse-width meter
// Assumes: all pins synchronous to clk; timebases are enables
// Notes: CNT_W is 16 or 24; overflow flag can set only at 16
//
// Contract
// - Train counter runs a finite train only while the gate pulse is high; a continuous train runs ungated.
// - Gate counter makes one delayed pulse lasting exactly the requested pulses.
// - One finite train holds at most 2^CNT_W minus one pulses.
// - Gate counter triggers once or retriggers on every further gate edge; edges arriving during the delay or the pulse are ignored.
// - Gate counter trigger comes from an external pin or another counter.
// - Start to first counted timebase edge may vary by one timebase period.
// - Train and gate counters stop, restart or reconfigure together, the meter alone, without global reset.
// - A train request with count minus one halts the running train.
// - Meter counts source edges while the measured pulse is active.
// - Final count equals timebase periods inside the measured pulse.
// - Sixteen-bit variant offers 1 MHz to 100 Hz internal timebases.
// - Twenty-four-bit variant offers 20 MHz or 100 kHz timebases.
// - Interval runs rising to falling or falling to rising, selectable.
// - Sixteen-bit variant flags terminal count as overflow, result invalid.
// - Sixteen-bit variant count register holds at most 65,535.
// - Continuous train operation never raises an overflow indication.
// - Meter output always shows current count and completion flag.
// - Meter source is internal timebase, external, train output or frequency.
`timescale 1ns/1ns
`include "gpc_defines.vh"

module gated_pulse_counter #(
	parameter CNT_W = 16
) (
	input  wire              clk,
	input  wire              rst_b,
	input  wire [2:0]        train_tb_sel,
	input  wire [CNT_W-1:0]  train_phase1,
	input  wire [CNT_W-1:0]  train_phase2,
	input  wire [CNT_W:0]    train_count,
	input  wire              train_start,
	input  wire              train_stop,
	input  wire [CNT_W-1:0]  gate_delay,
	input  wire              gate_wait_edge,
	input  wire              gate_retrigger,
	input  wire              gate_trig_sel,
	input  wire              ext_gate,
	input  wire              other_counter_out,
	input  wire [2:0]        meas_tb_sel,
	input  wire [1:0]        meas_src_sel,
	input  wire              meas_falling,
	input  wire              meas_arm,
	input  wire              meas_stop,
	input  wire              meas_gate,
	input  wire              ext_source,
	input  wire              divided_freq_output,
	output reg               train_out,
	output reg               train_busy,
	output reg               gate_pulse,
	output reg  [CNT_W-1:0]  meas_count,
	output reg               meas_done,
	output reg               meas_overflow,
	output reg               meas_valid
);

// ----------------------------------------
// Local constants
// ----------------------------------------
localparam             OVF_EN   = (CNT_W == 16);
localparam             PROD_W   = 2 * CNT_W + 1;
localparam [CNT_W:0]   HALT_CNT = {(CNT_W+1){1'b1}};
localparam [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
localparam [CNT_W-1:0] CNT_TOP  = {CNT_W{1'b1}};
localparam [PROD_W-1:0] PROD_ONE = {{(PROD_W-1){1'b0}}, 1'b1};

localparam [1:0] G_IDLE  = 2'h0;
localparam [1:0] G_WAIT  = 2'h1;
localparam [1:0] G_DELAY = 2'h2;
localparam [1:0] G_PULSE = 2'h3;

localparam [1:0] M_IDLE  = 2'h0;
localparam [1:0] M_ARMED = 2'h1;
localparam [1:0] M_COUNT = 2'h2;
localparam [1:0] M_DONE  = 2'h3;

// ----------------------------------------
// Functions
// ----------------------------------------
// Picks the selected timebase tick for this variant
function select_tick;
	input [2:0]         sel;
	input [`TICK_N-1:0] t;
	begin
		if (CNT_W == 16) begin
			case (sel)
				3'h0:    select_tick = t[`TICK_1M];
				3'h1:    select_tick = t[`TICK_100K];
				3'h2:    select_tick = t[`TICK_10K];
				3'h3:    select_tick = t[`TICK_1K];
				default: select_tick = t[`TICK_100HZ];
			endcase
		end else begin
			select_tick = (sel == 3'h0) ? t[`TICK_20M] : t[`TICK_100K];
		end
	end
endfunction

// Phase lengths of zero act as one tick
function [CNT_W-1:0] at_least_one;
	input [CNT_W-1:0] v;
	begin
		at_least_one = (v == {CNT_W{1'b0}}) ? CNT_ONE : v;
	end
endfunction

// ----------------------------------------
// Timebases and edges
// ----------------------------------------
wire [`TICK_N-1:0] tick;
wire [3:0]         pin_rise;

timebase_gen u_timebase (
	.clk   (clk),
	.rst_b (rst_b),
	.tick  (tick)
);

edge_detect #(
	.W (4)
) u_edges (
	.clk   (clk),
	.rst_b (rst_b),
	.d     ({divided_freq_output, ext_source, other_counter_out, ext_gate}),
	.rise  (pin_rise),
	.fall  ()
);

wire train_tick = select_tick(train_tb_sel, tick);
wire meas_tick  = select_tick(meas_tb_sel, tick);

// ----------------------------------------
// Train request decode
// ----------------------------------------
// minus one means halt
wire train_halt  = train_start && (train_count == HALT_CNT);
wire train_go    = train_start && !train_halt;
wire stop_all    = train_stop || train_halt;
wire [CNT_W-1:0] ph1 = at_least_one(train_phase1);
wire [CNT_W-1:0] ph2 = at_least_one(train_phase2);
wire [CNT_W:0]   period = {1'b0, ph1} + {1'b0, ph2};
// count field holds at most all-ones in CNT_W bits
wire [CNT_W-1:0] pulses = train_count[CNT_W-1:0];
wire [PROD_W-1:0] next_width = pulses * period;

reg               finite;
reg               train_phase;
reg  [CNT_W-1:0]  train_cnt;
reg  [1:0]        gate_state;
reg  [PROD_W-1:0] gate_cnt;
reg  [PROD_W-1:0] gate_width;
reg  [CNT_W-1:0]  gate_len;

// finite trains gated by the gate pulse level
wire train_gate = finite ? gate_pulse : 1'b1;
wire [CNT_W-1:0] phase_last = train_phase ? ph2 - CNT_ONE : ph1 - CNT_ONE;

// ----------------------------------------
// Train counter
// ----------------------------------------
// no overflow logic exists for the train
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		train_busy  <= 1'b0;
		train_out   <= 1'b0;
		train_phase <= 1'b0;
		train_cnt   <= {CNT_W{1'b0}};
		finite      <= 1'b0;
	end else if (stop_all) begin
		train_busy  <= 1'b0;
		train_out   <= 1'b0;
		train_phase <= 1'b0;
		train_cnt   <= {CNT_W{1'b0}};
	end else if (train_go) begin
		train_busy  <= 1'b1;
		train_out   <= 1'b0;
		train_phase <= 1'b0;
		train_cnt   <= {CNT_W{1'b0}};
		finite      <= (pulses != {CNT_W{1'b0}});
	end else if (!train_busy || !train_gate) begin
		// idle and rewound while gate low
		train_out   <= 1'b0;
		train_phase <= 1'b0;
		train_cnt   <= {CNT_W{1'b0}};
	end else if (train_tick) begin
		// first tick follows start by up to one period
		if (train_cnt == phase_last) begin
			train_cnt   <= {CNT_W{1'b0}};
			train_phase <= ~train_phase;
			train_out   <= ~train_phase;
		end else begin
			train_cnt   <= train_cnt + CNT_ONE;
		end
	end
end

// ----------------------------------------
// Gate counter (delayed single pulse)
// ----------------------------------------
// external pin or another counter triggers
wire gate_trig = (gate_trig_sel == `GTRIG_COUNTER) ? pin_rise[1] : pin_rise[0];
wire [CNT_W-1:0] delay_last = at_least_one(gate_len) - CNT_ONE;

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		gate_state <= G_IDLE;
		gate_pulse <= 1'b0;
		gate_cnt   <= {PROD_W{1'b0}};
		gate_width <= {PROD_W{1'b0}};
		gate_len   <= {CNT_W{1'b0}};
	end else if (stop_all) begin
		gate_state <= G_IDLE;
		gate_pulse <= 1'b0;
		gate_cnt   <= {PROD_W{1'b0}};
	end else if (train_go) begin
		// width is pulses times the train period
		gate_width <= next_width;
		gate_len   <= gate_delay;
		gate_pulse <= 1'b0;
		gate_cnt   <= {PROD_W{1'b0}};
		if (pulses == {CNT_W{1'b0}}) begin
			gate_state <= G_IDLE;
		end else if (gate_wait_edge) begin
			gate_state <= G_WAIT;
		end else begin
			gate_state <= G_DELAY;
		end
	end else begin
		case (gate_state)
			G_WAIT: begin
				if (gate_trig) begin
					gate_state <= G_DELAY;
					gate_cnt   <= {PROD_W{1'b0}};
				end
			end
			G_DELAY: begin
				if (train_tick) begin
					if (gate_cnt[CNT_W-1:0] == delay_last) begin
						gate_state <= G_PULSE;
						gate_pulse <= 1'b1;
						gate_cnt   <= {PROD_W{1'b0}};
					end else begin
						gate_cnt   <= gate_cnt + PROD_ONE;
					end
				end
			end
			G_PULSE: begin
				if (train_tick) begin
					if (gate_cnt == gate_width - PROD_ONE) begin
						gate_pulse <= 1'b0;
						gate_cnt   <= {PROD_W{1'b0}};
						// retrigger waits for the next edge
						gate_state <= gate_retrigger ? G_WAIT : G_IDLE;
					end else begin
						gate_cnt   <= gate_cnt + PROD_ONE;
					end
				end
			end
			default: begin
				gate_state <= G_IDLE;
				gate_pulse <= 1'b0;
			end
		endcase
	end
end

// ----------------------------------------
// Pulse-width meter
// ----------------------------------------
reg  [1:0] meas_state;
reg        train_out_last;

reg src_edge;
always @* begin
	case (meas_src_sel)
		`SRC_INTERNAL: src_edge = meas_tick;
		`SRC_EXTERNAL: src_edge = pin_rise[2];
		`SRC_TRAIN:    src_edge = train_out && !train_out_last;
		default:       src_edge = pin_rise[3];
	endcase
end

wire meas_rise;
wire meas_fall;
wire open_edge  = meas_falling ? meas_fall : meas_rise;
wire close_edge = meas_falling ? meas_rise : meas_fall;
wire meas_level = meas_falling ? !meas_gate : meas_gate;
reg  meas_gate_last;
assign meas_rise = meas_gate && !meas_gate_last;
assign meas_fall = !meas_gate && meas_gate_last;

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		meas_gate_last <= 1'b0;
		train_out_last <= 1'b0;
	end else begin
		meas_gate_last <= meas_gate;
		train_out_last <= train_out;
	end
end

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		meas_state    <= M_IDLE;
		meas_count    <= {CNT_W{1'b0}};
		meas_done     <= 1'b0;
		meas_overflow <= 1'b0;
		meas_valid    <= 1'b0;
	end else if (meas_arm) begin
		meas_state    <= M_ARMED;
		meas_count    <= {CNT_W{1'b0}};
		meas_done     <= 1'b0;
		meas_overflow <= 1'b0;
		meas_valid    <= 1'b0;
	end else if (meas_stop) begin
		meas_state    <= M_IDLE;
	end else begin
		case (meas_state)
			M_ARMED: begin
				if (open_edge) begin
					meas_state <= M_COUNT;
				end
			end
			M_COUNT: begin
				if (close_edge || !meas_level) begin
					meas_state <= M_DONE;
					meas_done  <= 1'b1;
					meas_valid <= !meas_overflow;
				end else if (src_edge) begin
					if (meas_count == CNT_TOP) begin
						if (OVF_EN) begin
							meas_overflow <= 1'b1;
						end
						meas_count <= {CNT_W{1'b0}};
					end else begin
						meas_count <= meas_count + CNT_ONE;
					end
				end
			end
			M_DONE: begin
				meas_state <= M_DONE;
			end
			default: begin
				meas_state <= M_IDLE;
			end
		endcase
	end
end

endmodule // gated_pulse_counter

// ==== rtl/gpc_defines.vh ====
// Purpose: constants shared by the gated pulse counter pair
// Assumes: 100 MHz system clock
// Notes: all timebases derive from the one clock as enable pulses
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH

// ----------------------------------------
// Clock and timebase rates (Hz)
// ----------------------------------------
`define CLK_HZ        100000000
`define TB_20M_HZ     20000000
`define TB_1M_HZ      1000000
`define DECADE        10
`define DIV_20M       (`CLK_HZ / `TB_20M_HZ)
`define DIV_1M        (`CLK_HZ / `TB_1M_HZ)

// ----------------------------------------
// Tick vector positions of timebase_gen
// ----------------------------------------
`define TICK_20M      0
`define TICK_1M       1
`define TICK_100K     2
`define TICK_10K      3
`define TICK_1K       4
`define TICK_100HZ    5
`define TICK_N        6

// ----------------------------------------
// Measurement source select codes
// ----------------------------------------
`define SRC_INTERNAL  2'h0
`define SRC_EXTERNAL  2'h1
`define SRC_TRAIN     2'h2
`define SRC_FREQ      2'h3

// ----------------------------------------
// Gate counter trigger source codes
// ----------------------------------------
`define GTRIG_EXT     1'h0
`define GTRIG_COUNTER 1'h1

`endif

// ==== rtl/timebase_gen.v ====
// Purpose: divides the clock into one-cycle timebase enable pulses
// Assumes: 100 MHz clock
// Notes: decades chained after the divide-by-100 1 MHz stage, so no later count exceeds ten
`timescale 1ns/1ns
`include "gpc_defines.vh"

module timebase_gen #(
	parameter DIV_FAST = `DIV_20M,
	parameter DIV_SLOW = `DIV_1M
) (
	input  wire                 clk,
	input  wire                 rst_b,
	output reg  [`TICK_N-1:0]   tick
);

localparam integer FAST_END  = DIV_FAST - 1;
localparam integer SLOW_END  = DIV_SLOW - 1;
localparam integer DEC_END   = `DECADE - 1;
localparam [2:0]   FAST_LAST = FAST_END[2:0];
localparam [6:0]   SLOW_LAST = SLOW_END[6:0];
localparam [3:0]   DEC_LAST  = DEC_END[3:0];

reg  [2:0] fast_cnt;
reg  [6:0] slow_cnt;
reg  [3:0] dec_cnt [0:3];
reg  [4:0] carry;
integer    i;
integer    j;

// ----------------------------------------
// Decade carry chain
// ----------------------------------------
always @* begin
	carry[0] = (slow_cnt == SLOW_LAST);
	for (j = 0; j < 4; j = j + 1) begin
		carry[j+1] = carry[j] && (dec_cnt[j] == DEC_LAST);
	end
end

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		fast_cnt <= 3'h0;
		slow_cnt <= 7'h00;
		tick     <= {`TICK_N{1'b0}};
		for (i = 0; i < 4; i = i + 1) begin
			dec_cnt[i] <= 4'h0;
		end
	end else begin
		fast_cnt <= (fast_cnt == FAST_LAST) ? 3'h0 : fast_cnt + 3'h1;
		slow_cnt <= carry[0] ? 7'h00 : slow_cnt + 7'h01;
		tick[`TICK_20M] <= (fast_cnt == FAST_LAST);
		tick[`TICK_1M]  <= carry[0];
		for (i = 0; i < 4; i = i + 1) begin
			if (carry[i]) begin
				dec_cnt[i] <= carry[i+1] ? 4'h0 : dec_cnt[i] + 4'h1;
			end
			tick[`TICK_100K+i] <= carry[i+1];
		end
	end
end

endmodule // timebase_gen

// ==== rtl/edge_detect.v ====
// Purpose: rising and falling edge detection on a group of inputs
// Assumes: inputs already synchronous to clk
// Notes: edges show in the cycle the input changes
`timescale 1ns/1ns

module edge_detect #(
	parameter W = 4
) (
	input  wire          clk,
	input  wire          rst_b,
	input  wire [W-1:0]  d,
	output wire [W-1:0]  rise,
	output wire [W-1:0]  fall
);

reg [W-1:0] last;

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		last <= {W{1'b0}};
	end else begin
		last <= d;
	end
end

assign rise = d & ~last;
assign fall = ~d & last;

endmodule // edge_detect

// ==== tb/gated_pulse_counter_props.sv ====
// Purpose: port assertions for the gated pulse counter pair
// Assumes: one clock domain, async active-low reset
// Notes: bound into every instance of the block
`timescale 1ns/1ns

module gated_pulse_counter_props #(
	parameter CNT_W = 16
) (
	input wire              clk,
	input wire              rst_b,
	input wire [CNT_W:0]    train_count,
	input wire              train_start,
	input wire              train_stop,
	input wire              meas_arm,
	input wire              train_out,
	input wire              train_busy,
	input wire              gate_pulse,
	input wire [CNT_W-1:0]  meas_count,
	input wire              meas_done,
	input wire              meas_overflow,
	input wire              meas_valid
);
	localparam [CNT_W:0]   HALT = {(CNT_W+1){1'b1}};
	localparam [CNT_W-1:0] TOP  = {CNT_W{1'b1}};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_halt; train_start && train_count == HALT |=> !train_busy && !gate_pulse && !train_out; endproperty
	a_halt: assert property (p_halt) else $error("halt left the train running");
	property p_start; train_start && !train_stop && train_count != HALT |=> train_busy; endproperty
	a_start: assert property (p_start) else $error("start did not enable the train");
	property p_stop; train_stop |=> !train_busy && !gate_pulse; endproperty
	a_stop: assert property (p_stop) else $error("stop did not halt train and gate");
	property p_hold; meas_done && !meas_arm |=> meas_done && $stable(meas_count) && $stable(meas_overflow); endproperty
	a_hold: assert property (p_hold) else $error("result moved after completion");
	property p_valid; meas_done |-> meas_valid == !meas_overflow; endproperty
	a_valid: assert property (p_valid) else $error("valid does not match overflow");
	property p_step; !$past(meas_arm) && meas_count != $past(meas_count) |-> meas_count == $past(meas_count) + 1'b1; endproperty
	a_step: assert property (p_step) else $error("count moved by other than one");
	property p_wrap; !$past(meas_arm) && $past(meas_count) == TOP && meas_count == 0 |-> CNT_W != 16 || meas_overflow; endproperty
	a_wrap: assert property (p_wrap) else $error("terminal count not flagged");
	property p_arm; meas_arm |=> meas_count == 0 && !meas_done && !meas_overflow && !meas_valid; endproperty
	a_arm: assert property (p_arm) else $error("arm did not clear the result");
endmodule // gated_pulse_counter_props

bind gated_pulse_counter gated_pulse_counter_props #(.CNT_W(CNT_W)) props_i (
	.clk, .rst_b, .train_count, .train_start, .train_stop, .meas_arm, .train_out,
	.train_busy, .gate_pulse, .meas_count, .meas_done, .meas_overflow, .meas_valid
);

// ==== tb/pulse_source.sv ====
// Purpose: external gate, trigger and source signals for the counter pair
// Assumes: every change follows a rising clk edge
// Notes: sources run free; gates and triggers move only on request
`timescale 1ns/1ns

module pulse_source (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic meas_idle,
	output logic      meas_gate,
	output logic      ext_gate,
	output logic      other_counter_out,
	output logic      ext_source,
	output logic      divided_freq_output
);
	logic [2:0] div;
	logic       meas_act = 1'b0;

	initial ext_gate = 1'b0;
	initial other_counter_out = 1'b0;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			div <= 3'h0;
		else
			div <= div + 3'h1;
	end
	assign ext_source          = div[2];
	assign divided_freq_output = div[1];
	assign meas_gate           = meas_idle ^ meas_act;

	task meas_pulse(input int w);
		@(posedge clk);
		meas_act <= 1'b1;
		repeat (w) @(posedge clk);
		meas_act <= 1'b0;
	endtask

	// trigger on pin or counter output
	task trig(input bit from_counter);
		@(posedge clk);
		if (from_counter)
			other_counter_out <= 1'b1;
		else
			ext_gate <= 1'b1;
		repeat (4) @(posedge clk);
		other_counter_out <= 1'b0;
		ext_gate <= 1'b0;
	endtask
endmodule // pulse_source

// ==== tb/gated_pulse_counter_tb.sv ====
// Purpose: self-checking bench for the gated pulse counter pair
// Assumes: 16-bit variant, 100 MHz clock
// Notes: counts are chosen so windows hold whole source periods
`timescale 1ns/1ns

module gated_pulse_counter_tb;
	localparam        CNT_W = 16;
	localparam [16:0] HALT  = 17'h1FFFF;
	logic             clk = 1'b0;
	logic             rst_b = 1'b0;
	logic [2:0]       train_tb_sel = 3'h0, meas_tb_sel = 3'h0;
	logic [15:0]      train_phase1 = 16'h0001, train_phase2 = 16'h0001, gate_delay = 16'h0001;
	logic [16:0]      train_count = 17'h00000;
	logic             train_start = 1'b0, train_stop = 1'b0, meas_arm = 1'b0, meas_stop = 1'b0;
	logic             gate_wait_edge = 1'b0, gate_retrigger = 1'b0, gate_trig_sel = 1'b0;
	logic [1:0]       meas_src_sel = 2'h0;
	logic             meas_falling = 1'b0;
	logic             ext_gate, other_counter_out, meas_gate, ext_source, divided_freq_output;
	logic             train_out, train_busy, gate_pulse, meas_done, meas_overflow, meas_valid;
	logic [15:0]      meas_count;
	logic             prev_out = 1'b0, finite = 1'b0;
	int               n_mismatch = 0, compares = 0, cycles = 0, n_rise = 0, r0;

	gated_pulse_counter #(.CNT_W(CNT_W)) gated_pulse_counter_i (
		.clk, .rst_b, .train_tb_sel, .train_phase1, .train_phase2, .train_count, .train_start,
		.train_stop, .gate_delay, .gate_wait_edge, .gate_retrigger, .gate_trig_sel, .ext_gate,
		.other_counter_out, .meas_tb_sel, .meas_src_sel, .meas_falling, .meas_arm, .meas_stop,
		.meas_gate, .ext_source, .divided_freq_output, .train_out, .train_busy, .gate_pulse,
		.meas_count, .meas_done, .meas_overflow, .meas_valid
	);

	pulse_source pulse_source_i (
		.clk, .rst_b, .meas_idle(meas_falling), .meas_gate, .ext_gate, .other_counter_out,
		.ext_source, .divided_freq_output
	);

	initial begin
		forever #5 clk = ~clk;
	end

	task results;
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Monitor and timeout
	// ----------------------------------------
	always @(posedge clk) begin
		cycles <= cycles + 1;
		prev_out <= train_out;
		if (cycles == 40000) begin
			n_mismatch++;
			results();
		end
		if (rst_b && train_out && !prev_out)
			n_rise <= n_rise + 1;
		if (finite && train_out === 1'b1 && gate_pulse !== 1'b1)
			check(gate_pulse, 1);
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task train_go(input logic [16:0] n, input logic [15:0] dly, input logic we);
		@(posedge clk);
		train_count <= n;
		gate_delay <= dly;
		gate_wait_edge <= we;
		train_start <= 1'b1;
		@(posedge clk);
		train_start <= 1'b0;
	endtask

	task strobe(input int k);
		@(posedge clk);
		case (k)
			0: train_stop <= 1'b1;
			1: meas_arm <= 1'b1;
			default: meas_stop <= 1'b1;
		endcase
		@(posedge clk);
		train_stop <= 1'b0;
		meas_arm <= 1'b0;
		meas_stop <= 1'b0;
	endtask

	task measure(input int src, input int tb, input int fall, input int w, input int exp);
		@(posedge clk);
		meas_src_sel <= src[1:0];
		meas_tb_sel <= tb[2:0];
		meas_falling <= fall[0];
		repeat (4) @(posedge clk);
		strobe(1);
		repeat (10) @(posedge clk);
		pulse_source_i.meas_pulse(w);
		repeat (6) @(posedge clk);
		check(meas_done, 1);
		check(meas_valid, 1);
		check(meas_overflow, 0);
		check(meas_count, exp);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		train_go(0, 1, 0);
		repeat (3) @(posedge clk);
		check(train_busy, 1);
		measure(2, 0, 0, 2001, 10);
		train_go(HALT, 1, 0);
		repeat (2) @(posedge clk);
		check({train_busy, train_out, gate_pulse}, 0);
		finite = 1'b1;
		r0 = n_rise;
		train_go(3, 2, 0);
		repeat (1400) @(posedge clk);
		check(n_rise - r0, 3);
		train_go(17'h0FFFF, 1, 0);
		repeat (3) @(posedge clk);
		check(train_busy, 1);
		strobe(0);
		@(posedge clk);
		check(train_busy, 0);
		gate_retrigger <= 1'b1;
		r0 = n_rise;
		train_go(2, 1, 1);
		pulse_source_i.trig(0);
		repeat (800) @(posedge clk);
		pulse_source_i.trig(0);
		repeat (800) @(posedge clk);
		gate_trig_sel <= 1'b1;
		gate_retrigger <= 1'b0;
		pulse_source_i.trig(1);
		repeat (800) @(posedge clk);
		pulse_source_i.trig(1);
		repeat (800) @(posedge clk);
		check(n_rise - r0, 6);
		strobe(0);
		finite = 1'b0;
		measure(0, 0, 0, 1001, 10);
		measure(0, 1, 1, 10001, 10);
		measure(1, 0, 0, 401, 50);
		measure(3, 0, 1, 401, 100);
		strobe(2);
		check(meas_count, 100);
		fork
			pulse_source_i.meas_pulse(300);
			strobe(1);
		join
		repeat (6) @(posedge clk);
		check({meas_done, meas_count}, 0);
		results();
	end
endmodule // gated_pulse_counter_tb
